/* File: usb_port_pkg.sv */
/*
  Shared constants and types for the root hub port status/control block:
  register offsets, bit positions, reset value, timing counts and carriers.
  Assumes a 100 MHz controller clock and base-relative I/O byte addresses.
*/
`default_nettype none
package usb_port_pkg;
  localparam int NPORTS = 2;
  localparam logic [4:0] PORT0_OFS = 5'h10;
  localparam logic [4:0] PORT1_OFS = 5'h12;
  localparam logic [15:0] PORT_RESET_VAL = 16'h0080;
  // ------------------------------------------------------------------
  // status/control bit positions
  // ------------------------------------------------------------------
  localparam int BIT_CONN = 0;
  localparam int BIT_CONN_CHG = 1;
  localparam int BIT_EN = 2;
  localparam int BIT_EN_CHG = 3;
  localparam int BIT_LINE_DP = 4;
  localparam int BIT_LINE_DM = 5;
  localparam int BIT_RESUME = 6;
  localparam int BIT_ONE = 7;
  localparam int BIT_LOW_SPEED = 8;
  localparam int BIT_PORT_RST = 9;
  localparam int BIT_OC = 10;
  localparam int BIT_OC_CHG = 11;
  localparam int BIT_SUSP = 12;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LS_BIT_NS = 667;
  localparam int CONNECT_SETTLE_NS = 2666;
  localparam logic [7:0] LS_BIT_CYC = 8'((LS_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] EOP_SE0_CYC = 8'(2 * LS_BIT_CYC);
  localparam logic [7:0] EOP_J_CYC = LS_BIT_CYC;
  localparam logic [8:0] CONNECT_SETTLE_CYC = 9'(CONNECT_SETTLE_NS / CLK_PERIOD_NS);
  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_K = 2'b01,
    DRV_SE0 = 2'b10,
    DRV_J = 2'b11
  } drv_state_t;
  typedef enum logic [1:0] {
    PORT_DISABLED = 2'b00,
    PORT_ENABLED = 2'b01,
    PORT_SUSPENDED = 2'b10
  } port_state_t;
  typedef struct packed {
    logic dp;
    logic dm;
    logic overcurrent_in_n;
    logic fault;
  } port_line_in_t;
  typedef struct packed {
    logic oe;
    logic dp;
    logic dm;
    logic block;
  } port_line_out_t;
endpackage
`default_nettype wire

/* File: usb_root_port_status_control.sv */
/*
  Two root hub downstream ports: connect, enable, suspend, resume, reset,
  over-current and speed state, plus reset/K/EOP drive on the port lines.
  Assumes all inputs synchronous to ref_clk; eof2_tick is a one-cycle pulse
  at the end-of-frame checkpoint; xact_busy marks a bus transaction.
*/
`default_nettype none
// Contract
// - one 16-bit register per port at 10h and 12h, word writes only
// - any reset: no device, disabled, line status 00
// - attach reaches connected state and flags change within 4 low-speed bit times (2666 ns settle)
// - during global suspend, setting bits 6, 3 or 1 requests global resume
// - enable 0 disabled, suspend 0 enable 1 enabled, both 1 suspended
// - suspended port blocks downstream data except SE0 resets, still sees resume
// - suspend waits for end of a transaction in progress
// - falling over-current input sets change bit, write 1 clears
// - over-current bit mirrors low input and disables the port
// - port reset bit disables port and drives reset signaling
// - speed bit shows low-speed device, writes ignored
// - bit 7 always reads 1
// - software sets resume bit; hardware sets it on J-to-K while suspended
// - resume bit set and suspended drives K-state
// - clearing resume bit sends low-speed EOP; bit reads 1 until done
// - bits 5:4 show D- and D+ levels, captured at end-of-frame checkpoint
// - enable change set on disconnect or fault at checkpoint, write 1 clears
// - only software enables; hardware disables; bit follows actual state
module usb_root_port_status_control (
  // clock and resets
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic hc_reset,
  input wire logic global_reset,
  // controller context
  input wire logic global_suspend,
  input wire logic xact_busy,
  input wire logic eof2_tick,
  output logic global_resume,
  // i/o register port
  input wire logic [4:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [1:0] io_be,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  // port lines
  input wire usb_port_pkg::port_line_in_t [1:0] line_in,
  output var usb_port_pkg::port_line_out_t [1:0] line_out
);
  logic [1:0] conn_reg, conn_next, conn_chg_reg, conn_chg_next;
  logic [1:0] en_reg, en_next, en_chg_reg, en_chg_next;
  logic [1:0] en_pend_reg, en_pend_next, en_val_reg, en_val_next;
  logic [1:0] susp_reg, susp_next, sp_pend_reg, sp_pend_next, sp_val_reg, sp_val_next;
  logic [1:0] prst_reg, prst_next, ls_reg, ls_next, resume_reg, resume_next;
  logic [1:0] oc_prev_reg, oc_prev_next, oc_chg_reg, oc_chg_next;
  logic [1:0] line_reg [2];
  logic [1:0] line_next [2];
  logic [1:0] prev_reg [2];
  logic [1:0] prev_next [2];
  logic [8:0] settle_reg [2];
  logic [8:0] settle_next [2];
  logic [7:0] dcnt_reg [2];
  logic [7:0] dcnt_next [2];
  usb_port_pkg::drv_state_t drv_reg [2];
  usb_port_pkg::drv_state_t drv_next [2];
  usb_port_pkg::port_line_out_t [1:0] out_next;
  logic [15:0] rdata_next;
  logic gresume_next;
  logic [15:0] stat [2];
  logic wr_hit, oc_act, soft_rst, raw_conn, dis_evt, rd_clr;
  logic [1:0] cur;

  function automatic logic [4:0] port_offset(input int p);
    return (p == 0) ? usb_port_pkg::PORT0_OFS : usb_port_pkg::PORT1_OFS;
  endfunction

  // K pair {dp,dm}: full speed K has D- high, low speed K has D+ high
  function automatic logic [1:0] k_pair(input logic ls);
    return ls ? 2'b10 : 2'b01;
  endfunction

  function automatic usb_port_pkg::port_state_t port_state(input logic s, input logic e);
    if (!e) return usb_port_pkg::PORT_DISABLED;
    return s ? usb_port_pkg::PORT_SUSPENDED : usb_port_pkg::PORT_ENABLED;
  endfunction

  // ------------------------------------------------------------------
  // read view
  // ------------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < usb_port_pkg::NPORTS; p++) begin
      stat[p] = '0;
      stat[p][usb_port_pkg::BIT_CONN] = conn_reg[p];
      stat[p][usb_port_pkg::BIT_CONN_CHG] = conn_chg_reg[p];
      stat[p][usb_port_pkg::BIT_EN] = en_reg[p];
      stat[p][usb_port_pkg::BIT_EN_CHG] = en_chg_reg[p];
      stat[p][usb_port_pkg::BIT_LINE_DP] = line_reg[p][1];
      stat[p][usb_port_pkg::BIT_LINE_DM] = line_reg[p][0];
      // stays 1 while the eop is still on the wire
      stat[p][usb_port_pkg::BIT_RESUME] = resume_reg[p] | drv_reg[p][1];
      stat[p][usb_port_pkg::BIT_ONE] = 1'b1;
      stat[p][usb_port_pkg::BIT_LOW_SPEED] = ls_reg[p];
      stat[p][usb_port_pkg::BIT_PORT_RST] = prst_reg[p];
      stat[p][usb_port_pkg::BIT_OC] = ~line_in[p].overcurrent_in_n;
      stat[p][usb_port_pkg::BIT_OC_CHG] = oc_chg_reg[p];
      stat[p][usb_port_pkg::BIT_SUSP] = susp_reg[p];
    end
  end

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    conn_next = conn_reg; conn_chg_next = conn_chg_reg;
    en_next = en_reg; en_chg_next = en_chg_reg;
    en_pend_next = en_pend_reg; en_val_next = en_val_reg;
    susp_next = susp_reg; sp_pend_next = sp_pend_reg; sp_val_next = sp_val_reg;
    prst_next = prst_reg; ls_next = ls_reg; resume_next = resume_reg;
    oc_prev_next = oc_prev_reg; oc_chg_next = oc_chg_reg;
    line_next = line_reg; prev_next = prev_reg; settle_next = settle_reg;
    dcnt_next = dcnt_reg; drv_next = drv_reg;
    out_next = '0; rdata_next = '0; gresume_next = 1'b0;
    wr_hit = 1'b0; oc_act = 1'b0; raw_conn = 1'b0; dis_evt = 1'b0; rd_clr = 1'b0;
    cur = '0;
    soft_rst = hc_reset | global_reset;
    for (int p = 0; p < usb_port_pkg::NPORTS; p++) begin
      // reserved bits 15:13 are dropped; partial writes are ignored
      wr_hit = io_wr && (io_be == 2'b11) && (io_addr == port_offset(p));
      if (io_rd && io_addr == port_offset(p)) rdata_next = stat[p];
      oc_act = ~line_in[p].overcurrent_in_n;
      cur = {line_in[p].dp, line_in[p].dm};
      prev_next[p] = cur;
      oc_prev_next[p] = line_in[p].overcurrent_in_n;
      // over-current change, set wins over clear
      oc_chg_next[p] = (oc_prev_reg[p] & ~line_in[p].overcurrent_in_n) |
                       (oc_chg_reg[p] & ~(wr_hit & io_wdata[usb_port_pkg::BIT_OC_CHG]));
      // connect filter, cleared while the port drives its own lines
      raw_conn = line_in[p].dp | line_in[p].dm;
      dis_evt = 1'b0;
      conn_chg_next[p] = conn_chg_reg[p] & ~(wr_hit & io_wdata[usb_port_pkg::BIT_CONN_CHG]);
      if (line_out[p].oe || raw_conn == conn_reg[p]) begin
        settle_next[p] = '0;
      end else if (settle_reg[p] == usb_port_pkg::CONNECT_SETTLE_CYC - 9'd1) begin
        settle_next[p] = '0;
        conn_next[p] = raw_conn;
        conn_chg_next[p] = 1'b1;
        if (raw_conn) ls_next[p] = line_in[p].dm;
        dis_evt = ~raw_conn;
      end else begin
        settle_next[p] = settle_reg[p] + 9'd1;
      end
      if (wr_hit) begin
        prst_next[p] = io_wdata[usb_port_pkg::BIT_PORT_RST];
        en_pend_next[p] = 1'b1;
        en_val_next[p] = io_wdata[usb_port_pkg::BIT_EN];
        sp_pend_next[p] = 1'b1;
        sp_val_next[p] = io_wdata[usb_port_pkg::BIT_SUSP];
        rd_clr = resume_reg[p] & ~io_wdata[usb_port_pkg::BIT_RESUME];
        resume_next[p] = io_wdata[usb_port_pkg::BIT_RESUME];
      end
      // enable/suspend follow the port only between transactions
      if (en_pend_reg[p] && !xact_busy) begin
        en_pend_next[p] = 1'b0;
        en_next[p] = en_val_reg[p] & conn_reg[p] & ~oc_act & ~prst_reg[p];
      end
      if (sp_pend_reg[p] && !xact_busy) begin
        sp_pend_next[p] = 1'b0;
        susp_next[p] = sp_val_reg[p];
      end
      en_chg_next[p] = en_chg_reg[p] & ~(wr_hit & io_wdata[usb_port_pkg::BIT_EN_CHG]);
      if (dis_evt && en_reg[p]) begin
        en_next[p] = 1'b0;
        en_chg_next[p] = 1'b1;
      end
      if (eof2_tick) begin
        line_next[p] = {line_in[p].dp, line_in[p].dm};
        if (en_reg[p] && (oc_act || line_in[p].fault)) begin
          en_next[p] = 1'b0;
          en_chg_next[p] = 1'b1;
        end
      end
      if (oc_act || prst_reg[p]) en_next[p] = 1'b0;
      if (!en_next[p]) susp_next[p] = 1'b0;
      if (susp_reg[p] && prev_reg[p] == ~k_pair(ls_reg[p]) && cur == k_pair(ls_reg[p]))
        resume_next[p] = 1'b1;
      case (drv_reg[p])
        usb_port_pkg::DRV_IDLE: begin
          if (resume_reg[p] && susp_reg[p]) drv_next[p] = usb_port_pkg::DRV_K;
        end
        usb_port_pkg::DRV_K: begin
          if (rd_clr) begin
            drv_next[p] = usb_port_pkg::DRV_SE0;
            dcnt_next[p] = '0;
          end else if (!susp_reg[p] || !resume_reg[p]) begin
            drv_next[p] = usb_port_pkg::DRV_IDLE;
          end
        end
        usb_port_pkg::DRV_SE0: begin
          dcnt_next[p] = dcnt_reg[p] + 8'd1;
          if (dcnt_reg[p] == usb_port_pkg::EOP_SE0_CYC - 8'd1) begin
            drv_next[p] = usb_port_pkg::DRV_J;
            dcnt_next[p] = '0;
          end
        end
        usb_port_pkg::DRV_J: begin
          dcnt_next[p] = dcnt_reg[p] + 8'd1;
          if (dcnt_reg[p] == usb_port_pkg::EOP_J_CYC - 8'd1) drv_next[p] = usb_port_pkg::DRV_IDLE;
        end
        default: drv_next[p] = usb_port_pkg::DRV_IDLE;
      endcase
      rd_clr = 1'b0;
      if (global_suspend && ((resume_next[p] & ~resume_reg[p]) |
          (en_chg_next[p] & ~en_chg_reg[p]) | (conn_chg_next[p] & ~conn_chg_reg[p])))
        gresume_next = 1'b1;
      if (soft_rst) begin
        conn_next[p] = 1'b0; conn_chg_next[p] = 1'b0; en_next[p] = 1'b0;
        en_chg_next[p] = 1'b0; en_pend_next[p] = 1'b0; susp_next[p] = 1'b0;
        sp_pend_next[p] = 1'b0; prst_next[p] = 1'b0; ls_next[p] = 1'b0;
        resume_next[p] = 1'b0; oc_chg_next[p] = 1'b0; line_next[p] = 2'b00;
        settle_next[p] = '0; drv_next[p] = usb_port_pkg::DRV_IDLE;
        gresume_next = 1'b0;
      end
      // line drive from the state just chosen
      if (prst_next[p] || global_reset) begin
        out_next[p].oe = 1'b1; // SE0 reset
      end else if (drv_next[p] == usb_port_pkg::DRV_K) begin
        out_next[p].oe = 1'b1;
        {out_next[p].dp, out_next[p].dm} = k_pair(ls_next[p]);
      end else if (drv_next[p] == usb_port_pkg::DRV_SE0) begin
        out_next[p].oe = 1'b1;
      end else if (drv_next[p] == usb_port_pkg::DRV_J) begin
        out_next[p].oe = 1'b1;
        {out_next[p].dp, out_next[p].dm} = ~k_pair(ls_next[p]);
      end
      // suspended port passes no downstream traffic besides the above
      out_next[p].block = susp_next[p] & ~prst_next[p] & ~global_reset;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      conn_reg <= '0; conn_chg_reg <= '0; en_reg <= '0; en_chg_reg <= '0;
      en_pend_reg <= '0; en_val_reg <= '0; susp_reg <= '0; sp_pend_reg <= '0;
      sp_val_reg <= '0; prst_reg <= '0; ls_reg <= '0; resume_reg <= '0;
      oc_prev_reg <= 2'b11; oc_chg_reg <= '0;
      line_reg <= '{default: 2'b00}; prev_reg <= '{default: 2'b00};
      settle_reg <= '{default: 9'h000}; dcnt_reg <= '{default: 8'h00};
      drv_reg <= '{default: usb_port_pkg::DRV_IDLE};
      line_out <= '0; io_rdata <= '0; global_resume <= 1'b0;
    end else begin
      conn_reg <= conn_next; conn_chg_reg <= conn_chg_next; en_reg <= en_next;
      en_chg_reg <= en_chg_next; en_pend_reg <= en_pend_next; en_val_reg <= en_val_next;
      susp_reg <= susp_next; sp_pend_reg <= sp_pend_next; sp_val_reg <= sp_val_next;
      prst_reg <= prst_next; ls_reg <= ls_next; resume_reg <= resume_next;
      oc_prev_reg <= oc_prev_next; oc_chg_reg <= oc_chg_next;
      line_reg <= line_next; prev_reg <= prev_next; settle_reg <= settle_next;
      dcnt_reg <= dcnt_next; drv_reg <= drv_next;
      line_out <= out_next; io_rdata <= rdata_next; global_resume <= gresume_next;
    end
  end

  // ------------------------------------------------------------------
  // checks (port 0; port 1 is the same logic)
  // ------------------------------------------------------------------
  localparam int CONN_BOUND = 300;
  logic w0;
  assign w0 = io_wr && io_be == 2'b11 && io_addr == usb_port_pkg::PORT0_OFS;

  property p_reset_state;
    @(posedge ref_clk) disable iff (!arst_n)
      hc_reset |=> stat[0][5:0] == 6'h00 && stat[0][usb_port_pkg::BIT_ONE];
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("port not clear after reset");
  property p_attach;
    @(posedge ref_clk) disable iff (!arst_n)
      (line_in[0].dp && !conn_reg[0] && !line_out[0].oe && !hc_reset && !global_reset)
        |-> ##[1:CONN_BOUND] (conn_reg[0] || !line_in[0].dp || line_out[0].oe || hc_reset);
  endproperty
  a_attach: assert property (p_attach) else $error("attach not seen in time");
  property p_gresume;
    @(posedge ref_clk) disable iff (!arst_n)
      (global_suspend && !soft_rst && conn_chg_next[0] && !conn_chg_reg[0]) |=> global_resume;
  endproperty
  a_gresume: assert property (p_gresume) else $error("no global resume");
  property p_state_decode;
    @(posedge ref_clk) disable iff (!arst_n)
      susp_reg[0] |-> en_reg[0] && port_state(susp_reg[0], en_reg[0]) == usb_port_pkg::PORT_SUSPENDED;
  endproperty
  a_state_decode: assert property (p_state_decode) else $error("suspended while disabled");
  property p_suspend_waits;
    @(posedge ref_clk) disable iff (!arst_n)
      (!susp_reg[0] && xact_busy) |=> !susp_reg[0];
  endproperty
  a_suspend_waits: assert property (p_suspend_waits) else $error("suspend in transaction");
  property p_oc_change;
    @(posedge ref_clk) disable iff (!arst_n)
      ($fell(line_in[0].overcurrent_in_n) && !soft_rst) |=> stat[0][usb_port_pkg::BIT_OC_CHG];
  endproperty
  a_oc_change: assert property (p_oc_change) else $error("over-current change missed");
  property p_oc_disable;
    @(posedge ref_clk) disable iff (!arst_n)
      !line_in[0].overcurrent_in_n [*2] |-> !en_reg[0];
  endproperty
  a_oc_disable: assert property (p_oc_disable) else $error("enabled under over-current");
  property p_port_reset;
    @(posedge ref_clk) disable iff (!arst_n)
      prst_reg[0] |-> !en_reg[0] ##0 (line_out[0].oe && !line_out[0].dp && !line_out[0].dm);
  endproperty
  a_port_reset: assert property (p_port_reset) else $error("port reset not driven");
  property p_speed_ro;
    @(posedge ref_clk) disable iff (!arst_n)
      (w0 && !soft_rst && settle_reg[0] != usb_port_pkg::CONNECT_SETTLE_CYC - 9'd1)
        |=> $stable(ls_reg[0]);
  endproperty
  a_speed_ro: assert property (p_speed_ro) else $error("speed bit written");
  property p_k_drive;
    @(posedge ref_clk) disable iff (!arst_n)
      (drv_reg[0] == usb_port_pkg::DRV_K && !prst_reg[0] && !global_reset) |->
        line_out[0].oe && {line_out[0].dp, line_out[0].dm} == k_pair(ls_reg[0]);
  endproperty
  a_k_drive: assert property (p_k_drive) else $error("k-state not driven");
  sequence s_resume_clear;
    w0 && !io_wdata[usb_port_pkg::BIT_RESUME] && drv_reg[0] == usb_port_pkg::DRV_K && !soft_rst;
  endsequence
  sequence s_eop_se0;
    (stat[0][usb_port_pkg::BIT_RESUME] && !line_out[0].dp && !line_out[0].dm) [*8];
  endsequence
  property p_eop;
    @(posedge ref_clk) disable iff (!arst_n)
      s_resume_clear |=> s_eop_se0;
  endproperty
  a_eop: assert property (p_eop) else $error("eop missing after resume clear");
endmodule
`default_nettype wire

/* File: usb_device_model.sv */
/*
  Behavioural attached usb device for one root hub port: attach/detach,
  speed, remote wake K, over-current and fault, resolved with host drive.
  Assumes control inputs change away from the rising edge of ref_clk.
*/
`default_nettype none
module usb_device_model (
  // device controls
  input wire logic attach,
  input wire logic low_speed,
  input wire logic resume_k,
  input wire logic oc_active,
  input wire logic fault_on,
  // wire resolution
  input wire usb_port_pkg::port_line_out_t host_out,
  output wire usb_port_pkg::port_line_in_t line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic j_dp;
  logic dev_dp;
  logic dev_dm;
  assign j_dp = ~low_speed;
  // detached lines fall to se0 through host pull-downs
  assign dev_dp = attach & (resume_k ? ~j_dp : j_dp);
  assign dev_dm = attach & (resume_k ? j_dp : ~j_dp);
  // host drive wins while oe is high
  assign line_in.dp = host_out.oe ? host_out.dp : dev_dp;
  assign line_in.dm = host_out.oe ? host_out.dm : dev_dm;
  assign line_in.overcurrent_in_n = ~oc_active;
  assign line_in.fault = fault_on;
endmodule
`default_nettype wire

/* File: tb_top.sv */
/*
  Self-checking bench for the two-port root hub status/control block:
  register reads and writes, attach, over-current, reset, suspend, resume.
  Assumes the register bus of single-cycle io_rd/io_wr strobes.
*/
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hc_reset = 1'b0;
  logic global_reset = 1'b0;
  logic global_suspend = 1'b0;
  logic xact_busy = 1'b0;
  logic eof2_tick = 1'b0;
  logic global_resume;
  logic [4:0] io_addr = 5'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [1:0] io_be = 2'h3;
  logic [15:0] io_wdata = 16'h0000;
  logic [15:0] io_rdata;
  wire usb_port_pkg::port_line_in_t [1:0] line_in;
  usb_port_pkg::port_line_out_t [1:0] line_out;
  logic attach = 1'b0;
  logic resume_k = 1'b0;
  logic oc_active = 1'b0;
  logic low_speed0 = 1'b0;
  logic fault0 = 1'b0;
  int resume_base = 0;
  int fails = 0;
  int checks_done = 0;
  int resume_seen = 0;
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  usb_root_port_status_control dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .hc_reset(hc_reset), .global_reset(global_reset), .global_suspend(global_suspend),
    .xact_busy(xact_busy), .eof2_tick(eof2_tick), .global_resume(global_resume),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_be(io_be), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .line_in(line_in), .line_out(line_out));
  usb_device_model dev0 (.attach(attach), .low_speed(low_speed0), .resume_k(resume_k),
    .oc_active(oc_active), .fault_on(fault0), .host_out(line_out[0]), .line_in(line_in[0]));
  usb_device_model dev1 (.attach(1'b0), .low_speed(1'b0), .resume_k(1'b0),
    .oc_active(1'b0), .fault_on(1'b0), .host_out(line_out[1]), .line_in(line_in[1]));
  // sampled away from the edge that launches the pulse
  always @(negedge ref_clk) begin
    if (global_resume === 1'b1) resume_seen++;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // whole-word write unless be says otherwise; bits 15:13 always zero
  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic [1:0] be = 2'h3);
    io_addr = a;
    io_wdata = d & 16'h1fff;
    io_be = be;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
    io_be = 2'h3;
    cyc(1);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    `CHK(io_rdata & m, e)
    cyc(1);
  endtask
  task automatic lines_chk(input logic [2:0] e);
    `CHK({line_out[0].oe, line_out[0].dp, line_out[0].dm}, e)
  endtask
  task automatic give_verdict();
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    cyc(5);
    arst_n = 1'b1;
    cyc(1);
    rd_chk(5'h10, 16'hffff, 16'h0080);
    rd_chk(5'h12, 16'hffff, 16'h0080);
    rd_chk(5'h14, 16'hffff, 16'h0000);
    attach = 1'b1;
    cyc(300);
    rd_chk(5'h10, 16'h0103, 16'h0003);
    wr(5'h10, 16'h0102);
    rd_chk(5'h10, 16'h0103, 16'h0001);
    wr(5'h10, 16'h0004, 2'h1);
    rd_chk(5'h10, 16'h0004, 16'h0000);
    wr(5'h10, 16'h0004);
    rd_chk(5'h10, 16'h1004, 16'h0004);
    eof2_tick = 1'b1;
    cyc(1);
    eof2_tick = 1'b0;
    rd_chk(5'h10, 16'h0030, 16'h0010);
    oc_active = 1'b1;
    cyc(3);
    rd_chk(5'h10, 16'h0c04, 16'h0c00);
    rd_chk(5'h12, 16'hffff, 16'h0080);
    oc_active = 1'b0;
    cyc(3);
    wr(5'h10, 16'h0800);
    rd_chk(5'h10, 16'h0c00, 16'h0000);
    // software holds reset for its own chosen length
    wr(5'h10, 16'h0200);
    cyc(2);
    lines_chk(3'b100);
    rd_chk(5'h10, 16'h0204, 16'h0200);
    wr(5'h10, 16'h0000);
    cyc(3);
    wr(5'h10, 16'h0004);
    xact_busy = 1'b1;
    wr(5'h10, 16'h1004);
    cyc(3);
    rd_chk(5'h10, 16'h1004, 16'h0004);
    `CHK(line_out[0].block, 1'b0)
    xact_busy = 1'b0;
    cyc(3);
    rd_chk(5'h10, 16'h1004, 16'h1004);
    `CHK(line_out[0].block, 1'b1)
    // suspend is set before global suspend, never during it
    global_suspend = 1'b1;
    resume_k = 1'b1;
    cyc(20);
    rd_chk(5'h10, 16'h0040, 16'h0040);
    lines_chk(3'b101);
    `CHK(resume_seen > 0, 1'b1)
    resume_k = 1'b0;
    global_suspend = 1'b0;
    wr(5'h10, 16'h1004);
    cyc(2);
    rd_chk(5'h10, 16'h0040, 16'h0040);
    lines_chk(3'b100);
    cyc(210);
    rd_chk(5'h10, 16'h0040, 16'h0000);
    `CHK(line_out[0].oe, 1'b0)
    fault0 = 1'b1;
    eof2_tick = 1'b1;
    cyc(1);
    eof2_tick = 1'b0;
    fault0 = 1'b0;
    rd_chk(5'h10, 16'h000c, 16'h0008);
    wr(5'h10, 16'h000c);
    rd_chk(5'h10, 16'h000c, 16'h0004);
    attach = 1'b0;
    cyc(300);
    rd_chk(5'h10, 16'h000f, 16'h000a);
    global_reset = 1'b1;
    cyc(2);
    lines_chk(3'b100);
    `CHK(line_out[1].oe, 1'b1)
    global_reset = 1'b0;
    cyc(1);
    rd_chk(5'h10, 16'hffff, 16'h0080);
    // connect change under global suspend must also wake the controller
    resume_base = resume_seen;
    global_suspend = 1'b1;
    low_speed0 = 1'b1;
    attach = 1'b1;
    cyc(300);
    rd_chk(5'h10, 16'h0103, 16'h0103);
    `CHK(resume_seen > resume_base, 1'b1)
    global_suspend = 1'b0;
    wr(5'h10, 16'h0000);
    rd_chk(5'h10, 16'h0100, 16'h0100);
    wr(5'h12, 16'h0002);
    hc_reset = 1'b1;
    cyc(2);
    hc_reset = 1'b0;
    cyc(1);
    rd_chk(5'h12, 16'hffff, 16'h0080);
    rd_chk(5'h10, 16'hffff, 16'h0080);
    give_verdict();
  end
endmodule
`default_nettype wire
